// ===== design/dma_event_defs.svh
`ifndef DMA_EVENT_DEFS_SVH
`define DMA_EVENT_DEFS_SVH

// register byte offsets
`define OFS_CRC_CONTROL 8'h00
`define OFS_CRC_VALUE 8'h04
`define OFS_CRC_TAP_MASK 8'h08
`define OFS_EVENT_CONTROL 8'h10
`define OFS_INT_CONTROL 8'h14
`define OFS_SOURCE_START 8'h18
`define OFS_SOURCE_SIZE 8'h1C
`define OFS_DEST_SIZE 8'h20
`define OFS_CELL_SIZE 8'h24
`define OFS_CHANNEL_CONTROL 8'h28
`define OFS_SOURCE_POINTER 8'h2C
`define OFS_DEST_POINTER 8'h30

// crc control fields
`define KIND_BIT 5
`define POLY_LENGTH_FIELD_HI 12
`define POLY_LENGTH_FIELD_LO 8
`define CRC_CONTROL_MASK 32'h00001F20

// event control fields
`define ECON_FORCE 7
`define ECON_ABORT 6
`define ECON_PATTERN_ABORT_ENABLE 5
`define ECON_START_TRIGGER_ENABLE 4
`define ECON_ABORT_TRIGGER_ENABLE 3
`define ECON_AIRQ_LO 16
`define ECON_SIRQ_LO 8
`define ECON_RESET 32'h00FFFF00
`define ECON_WMASK 32'h00FFFF38

// interrupt control: enables at 23:16, flags at 7:0
`define INT_EN_LO 16
`define FLAG_SRC_DONE 7
`define FLAG_SRC_HALF 6
`define FLAG_DST_DONE 5
`define FLAG_DST_HALF 4
`define FLAG_BLOCK 3
`define FLAG_CELL 2
`define FLAG_ABORT 1
`define FLAG_ADDR_ERR 0

// channel control fields
`define CHANNEL_ENABLE_BIT 0
`define BUSY_BIT 1

`endif

// ===== design/dma_event_pkg.sv
package dma_event_pkg;

    // channel sequencer states, gray along idle -> active
    typedef enum logic [1:0] {
        CH_IDLE = 2'b00,
        CH_ACTIVE = 2'b01
    } chan_state_t;

    typedef logic [7:0] flag_vec_t;

endpackage

// ===== design/dma_channel_event_and_crc.sv
//
// Overview of operation
// - checksum mode: value reads upper half zero
// - checksum mode: writes converted, reads ones-complement
// - lfsr mode: bits above length read zero
// - tap mask bits enable per-stage feedback
// - abort number selects interrupt 0 to 255
// - start number selects interrupt 0 to 255
// - force bit starts transfer, reads zero
// - abort bit aborts transfer, reads zero
// - pattern abort enable aborts, clears channel enable
// - start trigger enable launches one cell
// - abort trigger enable terminates transfer
// - enables at 23:16, flags at 7:0
// - source done when pointer reaches size
// - source half when pointer equals half size
// - destination done when pointer reaches size
// - destination half when pointer equals half size
// - block done on larger size or pattern
// - cell done after cell size bytes
// - abort flag on matching abort interrupt
// - address error flag on invalid address
// - tap mask full width, resets zero
// - kind bit: set checksum, clear lfsr
// - length field holds polynomial length minus one
//
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/10ps
`include "dma_event_defs.svh"

module dma_channel_event_and_crc
    import dma_event_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic irq_valid,
    input wire logic [7:0] irq_number,
    input wire logic pattern_match,
    input wire logic address_error,
    input wire logic src_byte_moved,
    input wire logic dst_byte_moved,
    input wire logic crc_data_valid,
    input wire logic [15:0] crc_data,
    output logic [31:0] source_start_address,
    output logic cell_start,
    output logic transfer_abort,
    output logic channel_busy,
    output logic channel_irq
);

    logic [31:0] crc_control, crc_value, crc_tap_mask, channel_event_control;
    logic [31:0] channel_interrupt_control, channel_source_start;
    logic [15:0] source_size, destination_size, cell_size;
    logic channel_enable, rd_ready;
    logic [16:0] source_pointer, destination_pointer, cell_count;
    chan_state_t state;

    logic [31:0] next_crc_control, next_crc_value, next_crc_tap_mask, next_event_control;
    logic [31:0] next_int_control, next_source_start, next_prdata;
    logic [15:0] next_source_size, next_destination_size, next_cell_size;
    logic next_channel_enable, next_rd_ready, next_cell_start, next_transfer_abort;
    logic [16:0] next_source_pointer, next_destination_pointer, next_cell_count;
    chan_state_t next_state;

    logic [31:0] wbe, len_mask, rd_mux;
    logic wr_en, rd_take, addr_ok, checksum_mode;
    logic start_hit, abort_hit, force_wr, abort_wr, pat_abort, any_abort;
    logic [16:0] eff_ssize, eff_dsize, eff_csize;
    flag_vec_t flag_set;

    // apb handshake: writes finish in the first access cycle, reads one later
    assign wr_en = ce && psel && penable && pwrite;
    assign rd_take = ce && psel && penable && !pwrite && !rd_ready;
    assign pready = ce && (pwrite || rd_ready);
    assign wbe = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
    assign checksum_mode = crc_control[`KIND_BIT];
    assign len_mask = 32'hFFFFFFFF >> (5'h1F - crc_control[`POLY_LENGTH_FIELD_HI:`POLY_LENGTH_FIELD_LO]);
    assign source_start_address = channel_source_start;
    assign channel_busy = (state == CH_ACTIVE);
    // the request is a plain level so the interrupt controller sees it at once
    assign channel_irq = |(channel_interrupt_control[`INT_EN_LO+7:`INT_EN_LO]
                           & channel_interrupt_control[7:0]);
    // a zero size means the full 64 KiB
    assign eff_ssize = {source_size == 16'h0000, source_size};
    assign eff_dsize = {destination_size == 16'h0000, destination_size};
    assign eff_csize = {cell_size == 16'h0000, cell_size};

    // read mux and address decode
    always_comb
    begin
        addr_ok = 1'b1;
        rd_mux = 32'h00000000;
        if (paddr == `OFS_CRC_CONTROL)
            rd_mux = crc_control;
        else if (paddr == `OFS_CRC_VALUE)
            rd_mux = checksum_mode ? {16'h0000, ~crc_value[15:0]}
                                   : (crc_value & len_mask);
        else if (paddr == `OFS_CRC_TAP_MASK)
            rd_mux = crc_tap_mask;
        else if (paddr == `OFS_EVENT_CONTROL)
            rd_mux = channel_event_control & `ECON_WMASK;
        else if (paddr == `OFS_INT_CONTROL)
            rd_mux = channel_interrupt_control;
        else if (paddr == `OFS_SOURCE_START)
            rd_mux = channel_source_start;
        else if (paddr == `OFS_SOURCE_SIZE)
            rd_mux = {16'h0000, source_size};
        else if (paddr == `OFS_DEST_SIZE)
            rd_mux = {16'h0000, destination_size};
        else if (paddr == `OFS_CELL_SIZE)
            rd_mux = {16'h0000, cell_size};
        else if (paddr == `OFS_CHANNEL_CONTROL)
            rd_mux = {30'h00000000, channel_busy, channel_enable};
        else if (paddr == `OFS_SOURCE_POINTER)
            rd_mux = {16'h0000, source_pointer[15:0]};
        else if (paddr == `OFS_DEST_POINTER)
            rd_mux = {16'h0000, destination_pointer[15:0]};
        else
            addr_ok = 1'b0;
        next_prdata = rd_take ? rd_mux : prdata;
        next_rd_ready = rd_take;
    end

    assign pslverr = pready && psel && penable && !addr_ok;

    // software-owned configuration registers
    always_comb
    begin
        next_crc_control = crc_control;
        next_crc_tap_mask = crc_tap_mask;
        next_event_control = channel_event_control;
        next_source_start = channel_source_start;
        next_source_size = source_size;
        next_destination_size = destination_size;
        next_cell_size = cell_size;
        if (wr_en && paddr == `OFS_CRC_CONTROL)
            next_crc_control = ((crc_control & ~wbe) | (pwdata & wbe)) & `CRC_CONTROL_MASK;
        else if (wr_en && paddr == `OFS_CRC_TAP_MASK)
            next_crc_tap_mask = (crc_tap_mask & ~wbe) | (pwdata & wbe);
        else if (wr_en && paddr == `OFS_EVENT_CONTROL)
            next_event_control = ((channel_event_control & ~wbe) | (pwdata & wbe)) & `ECON_WMASK;
        else if (wr_en && paddr == `OFS_SOURCE_START)
            next_source_start = (channel_source_start & ~wbe) | (pwdata & wbe);
        else if (wr_en && paddr == `OFS_SOURCE_SIZE)
            next_source_size = (source_size & ~wbe[15:0]) | (pwdata[15:0] & wbe[15:0]);
        else if (wr_en && paddr == `OFS_DEST_SIZE)
            next_destination_size = (destination_size & ~wbe[15:0]) | (pwdata[15:0] & wbe[15:0]);
        else if (wr_en && paddr == `OFS_CELL_SIZE)
            next_cell_size = (cell_size & ~wbe[15:0]) | (pwdata[15:0] & wbe[15:0]);
    end

    // crc engine: ones-complement sum or byte-wide lfsr with per-stage taps
    always_comb
    begin
        logic fb;
        logic [16:0] sum;
        fb = 1'b0;
        sum = 17'h00000;
        next_crc_value = crc_value;
        if (wr_en && paddr == `OFS_CRC_VALUE)
        begin
            // checksum seed is stored inverted so reads come back as written
            if (checksum_mode)
                next_crc_value = {16'h0000, ~pwdata[15:0]};
            else
                next_crc_value = pwdata;
        end
        else if (crc_data_valid && checksum_mode)
        begin
            sum = {1'b0, crc_value[15:0]} + {1'b0, crc_data};
            next_crc_value = {16'h0000, sum[15:0] + {15'h0000, sum[16]}};
        end
        else if (crc_data_valid)
        begin
            for (int i = 7; i >= 0; i--)
            begin
                fb = next_crc_value[crc_control[`POLY_LENGTH_FIELD_HI:`POLY_LENGTH_FIELD_LO]] ^ crc_data[i];
                next_crc_value = ({next_crc_value[30:0], 1'b0} ^ (crc_tap_mask & {32{fb}}));
            end
            next_crc_value = next_crc_value & len_mask;
        end
    end

    // triggers, channel sequencer, pointers and event flags
    always_comb
    begin
        force_wr = wr_en && paddr == `OFS_EVENT_CONTROL && pstrb[0] && pwdata[`ECON_FORCE];
        abort_wr = wr_en && paddr == `OFS_EVENT_CONTROL && pstrb[0] && pwdata[`ECON_ABORT];
        start_hit = channel_enable && irq_valid && channel_event_control[`ECON_START_TRIGGER_ENABLE]
                    && irq_number == channel_event_control[`ECON_SIRQ_LO+7:`ECON_SIRQ_LO];
        abort_hit = channel_enable && irq_valid && channel_event_control[`ECON_ABORT_TRIGGER_ENABLE]
                    && irq_number == channel_event_control[`ECON_AIRQ_LO+7:`ECON_AIRQ_LO];
        // with pattern abort off the match input is not looked at
        pat_abort = channel_enable && pattern_match && channel_event_control[`ECON_PATTERN_ABORT_ENABLE];
        any_abort = abort_hit || abort_wr || pat_abort;
        flag_set = 8'h00;
        next_state = state;
        next_channel_enable = channel_enable;
        next_source_pointer = source_pointer;
        next_destination_pointer = destination_pointer;
        next_cell_count = cell_count;
        next_cell_start = 1'b0;
        next_transfer_abort = 1'b0;
        if (wr_en && paddr == `OFS_CHANNEL_CONTROL && pstrb[0])
            next_channel_enable = pwdata[`CHANNEL_ENABLE_BIT];
        flag_set[`FLAG_ADDR_ERR] = address_error;
        if (any_abort)
        begin
            // abort wins over any start or byte movement in the same cycle
            next_state = CH_IDLE;
            next_source_pointer = 17'h00000;
            next_destination_pointer = 17'h00000;
            next_transfer_abort = 1'b1;
            flag_set[`FLAG_ABORT] = abort_hit;
            if (pat_abort)
            begin
                next_channel_enable = 1'b0;
                flag_set[`FLAG_BLOCK] = 1'b1;
            end
        end
        else
        begin
            case (state)
                CH_IDLE:
                begin
                    if (start_hit || force_wr)
                    begin
                        next_state = CH_ACTIVE;
                        next_cell_count = 17'h00000;
                        next_cell_start = 1'b1;
                    end
                end
                CH_ACTIVE:
                begin
                    if (src_byte_moved)
                    begin
                        next_source_pointer = source_pointer + 17'h00001;
                        flag_set[`FLAG_SRC_DONE] = next_source_pointer == eff_ssize;
                        flag_set[`FLAG_SRC_HALF] = next_source_pointer == (eff_ssize >> 1);
                    end
                    if (dst_byte_moved)
                    begin
                        next_destination_pointer = destination_pointer + 17'h00001;
                        next_cell_count = cell_count + 17'h00001;
                        flag_set[`FLAG_DST_DONE] = next_destination_pointer == eff_dsize;
                        flag_set[`FLAG_DST_HALF] = next_destination_pointer == (eff_dsize >> 1);
                    end
                    if (next_source_pointer >= eff_ssize && next_destination_pointer >= eff_dsize)
                    begin
                        // larger of the two sizes has been moved: block ends
                        flag_set[`FLAG_BLOCK] = 1'b1;
                        flag_set[`FLAG_CELL] = 1'b1;
                        next_state = CH_IDLE;
                        next_channel_enable = 1'b0;
                        next_source_pointer = 17'h00000;
                        next_destination_pointer = 17'h00000;
                    end
                    else if (next_cell_count == eff_csize)
                    begin
                        flag_set[`FLAG_CELL] = 1'b1;
                        next_state = CH_IDLE;
                    end
                end
                default:
                    next_state = CH_IDLE;
            endcase
        end
        // software clears a flag with a zero; a set in the same cycle wins
        next_int_control = channel_interrupt_control;
        if (wr_en && paddr == `OFS_INT_CONTROL)
            next_int_control = ((channel_interrupt_control & ~wbe) | (pwdata & wbe)) & 32'h00FF00FF;
        next_int_control[7:0] = next_int_control[7:0] | flag_set;
    end

    // state registers; ce low freezes everything
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            crc_control <= 32'h00000000;
            crc_value <= 32'h00000000;
            crc_tap_mask <= 32'h00000000;
            channel_event_control <= `ECON_RESET;
            channel_interrupt_control <= 32'h00000000;
            channel_source_start <= 32'h00000000;
            source_size <= 16'h0000;
            destination_size <= 16'h0000;
            cell_size <= 16'h0000;
            channel_enable <= 1'b0;
            source_pointer <= 17'h00000;
            destination_pointer <= 17'h00000;
            cell_count <= 17'h00000;
            state <= CH_IDLE;
            cell_start <= 1'b0;
            transfer_abort <= 1'b0;
            prdata <= 32'h00000000;
            rd_ready <= 1'b0;
        end
        else if (ce)
        begin
            crc_control <= next_crc_control;
            crc_value <= next_crc_value;
            crc_tap_mask <= next_crc_tap_mask;
            channel_event_control <= next_event_control;
            channel_interrupt_control <= next_int_control;
            channel_source_start <= next_source_start;
            source_size <= next_source_size;
            destination_size <= next_destination_size;
            cell_size <= next_cell_size;
            channel_enable <= next_channel_enable;
            source_pointer <= next_source_pointer;
            destination_pointer <= next_destination_pointer;
            cell_count <= next_cell_count;
            state <= next_state;
            cell_start <= next_cell_start;
            transfer_abort <= next_transfer_abort;
            prdata <= next_prdata;
            rd_ready <= next_rd_ready;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_crc_read;
        pready && psel && penable && !pwrite && paddr == `OFS_CRC_VALUE;
    endsequence

    sequence s_abort_irq;
        ce && abort_hit && state == CH_ACTIVE;
    endsequence

    property p_checksum_upper_zero;
        (s_crc_read and checksum_mode) |-> prdata[31:16] == 16'h0000;
    endproperty
    a_checksum_upper_zero: assert property (p_checksum_upper_zero) else $error("checksum upper half not zero");

    property p_checksum_write_inverted;
        (wr_en && paddr == `OFS_CRC_VALUE && pstrb == 4'hF && checksum_mode)
            |=> crc_value[15:0] == ~$past(pwdata[15:0]);
    endproperty
    a_checksum_write_inverted: assert property (p_checksum_write_inverted) else $error("checksum seed not converted");

    property p_lfsr_upper_zero;
        (s_crc_read and !checksum_mode) |-> (prdata & ~len_mask) == 32'h00000000;
    endproperty
    a_lfsr_upper_zero: assert property (p_lfsr_upper_zero) else $error("crc bits above length set");

    property p_tap_mask_write;
        (wr_en && paddr == `OFS_CRC_TAP_MASK && pstrb == 4'hF) |=> crc_tap_mask == $past(pwdata);
    endproperty
    a_tap_mask_write: assert property (p_tap_mask_write) else $error("tap mask write lost");

    property p_command_bits_read_zero;
        (pready && psel && penable && !pwrite && paddr == `OFS_EVENT_CONTROL) |-> prdata[7:6] == 2'b00;
    endproperty
    a_command_bits_read_zero: assert property (p_command_bits_read_zero) else $error("force or abort bit read as one");

    property p_start_irq_launch;
        (ce && start_hit && state == CH_IDLE && !any_abort) |=> cell_start && state == CH_ACTIVE;
    endproperty
    a_start_irq_launch: assert property (p_start_irq_launch) else $error("start interrupt did not launch cell");

    property p_abort_irq;
        s_abort_irq |=> transfer_abort && channel_interrupt_control[`FLAG_ABORT] && state == CH_IDLE;
    endproperty
    a_abort_irq: assert property (p_abort_irq) else $error("abort interrupt not honoured");

    property p_pattern_abort;
        (ce && pat_abort) |=> !channel_enable && channel_interrupt_control[`FLAG_BLOCK];
    endproperty
    a_pattern_abort: assert property (p_pattern_abort) else $error("pattern abort left channel enabled");

    property p_flag_sticky;
        (channel_interrupt_control[`FLAG_CELL] && !(wr_en && paddr == `OFS_INT_CONTROL))
            |=> channel_interrupt_control[`FLAG_CELL];
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag cleared by hardware");

    property p_irq_follows_flag;
        (ce && address_error && channel_interrupt_control[`INT_EN_LO + `FLAG_ADDR_ERR]) |=> channel_irq;
    endproperty
    a_irq_follows_flag: assert property (p_irq_follows_flag) else $error("enabled flag gave no interrupt");

endmodule // dma_channel_event_and_crc

// ===== sim/dma_far_model.sv
`timescale 1ns/10ps
module dma_far_model
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic cell_start,
    input wire logic transfer_abort,
    input wire logic [7:0] beats,
    input wire logic slow,
    output logic src_byte_moved,
    output logic dst_byte_moved
);
    logic [7:0] left;
    logic hold;
    // bytes still owed in this cell; an abort drops them at once
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            left <= 8'h00;
            hold <= 1'b0;
        end
        else
        begin
            hold <= slow && !hold;
            if (transfer_abort)
                left <= 8'h00;
            else if (cell_start)
                left <= beats;
            else if (left != 8'h00 && !hold)
                left <= left - 8'h01;
        end
    end
    // one read and one write per beat; slow idles every other cycle
    assign src_byte_moved = (left != 8'h00) && !hold;
    assign dst_byte_moved = (left != 8'h00) && !hold;
endmodule // dma_far_model

// ===== sim/dma_channel_event_and_crc_tb.sv
`timescale 1ns/10ps
`include "dma_event_defs.svh"
module dma_channel_event_and_crc_tb
    import dma_event_pkg::*;
;
    logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 0, irq_number = 0, beats = 0, s, a;
    logic [31:0] pwdata = 0, prdata, rd, v, seed = 28080, ssa;
    logic [3:0] pstrb = 4'hF;
    logic [15:0] crc_data = 0;
    logic pready, pslverr, er, sb, db, cs, ta, busy, irq, slow = 0;
    logic irq_valid = 0, pattern_match = 0, address_error = 0, crc_data_valid = 0;
    int n_mismatch = 0, n_compared = 0, cyc = 0;
    dma_channel_event_and_crc uut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq_valid(irq_valid), .irq_number(irq_number), .pattern_match(pattern_match),
        .address_error(address_error), .src_byte_moved(sb), .dst_byte_moved(db),
        .crc_data_valid(crc_data_valid), .crc_data(crc_data), .source_start_address(ssa),
        .cell_start(cs), .transfer_abort(ta), .channel_busy(busy), .channel_irq(irq));
    dma_far_model far (.pclk(pclk), .presetn(presetn), .cell_start(cs), .transfer_abort(ta),
        .beats(beats), .slow(slow), .src_byte_moved(sb), .dst_byte_moved(db));
    always #2 pclk = ~pclk;
    // hang guard: the whole sequence needs well under a thousand cycles
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_mismatch++;
            close_out();
        end
    end
    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // reference shift of one byte, msb first, four-stage polynomial
    function logic [31:0] lfsr(input logic [31:0] c, input logic [31:0] m, input logic [7:0] d);
        for (int i = 7; i >= 0; i--)
            c = {c[30:0], 1'b0} ^ (m & {32{c[3] ^ d[i]}});
        return c & 32'h0000000F;
    endfunction
    task close_out();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] want);
        n_compared++;
        if (seen !== want)
        begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    // one apb transfer; an idle cycle follows so psel is never assigned twice at one edge
    task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 40);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 40)
            n_mismatch++;
        @(posedge pclk);
    endtask
    task wr(input logic [7:0] ad, input logic [31:0] d);
        apb(1'b1, ad, d);
    endtask
    task rdc(input logic [7:0] ad, input logic [31:0] want);
        apb(1'b0, ad, 32'h0);
        check(rd, want);
    endtask
    // one interrupt pulse; the number line then shows a different value
    task fire(input logic [7:0] num);
        irq_valid <= 1'b1;
        irq_number <= num;
        @(posedge pclk);
        irq_valid <= 1'b0;
        irq_number <= ~num;
        @(posedge pclk);
    endtask
    task wait_idle();
        int k;
        k = 0;
        while (busy !== 1'b0 && k < 60)
        begin
            @(posedge pclk);
            k++;
        end
        if (k >= 60)
            n_mismatch++;
    endtask
    initial
    begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdc(`OFS_EVENT_CONTROL, 32'h00FFFF00);
        rdc(`OFS_CRC_TAP_MASK, 32'h0);
        rdc(`OFS_INT_CONTROL, 32'h0);
        repeat (4)
        begin
            v = rnd();
            wr(`OFS_CRC_TAP_MASK, v);
            rdc(`OFS_CRC_TAP_MASK, v);
            wr(`OFS_SOURCE_START, ~v);
            check(ssa, ~v);
        end
        apb(1'b0, 8'hFC, 32'h0);
        check(32'(er), 32'h00000001);
        check(rd, 32'h00000000);
        // checksum mode: a written value reads back unchanged, upper half zero
        wr(`OFS_CRC_CONTROL, 32'h20);
        v = rnd();
        wr(`OFS_CRC_VALUE, v);
        rdc(`OFS_CRC_VALUE, {16'h0, v[15:0]});
        wr(`OFS_CRC_VALUE, 32'hFFFF);
        crc_data_valid <= 1'b1;
        crc_data <= 16'h1234;
        @(posedge pclk);
        crc_data_valid <= 1'b0;
        @(posedge pclk);
        rdc(`OFS_CRC_VALUE, 32'h0000EDCB);
        // lfsr mode with a four-bit polynomial
        wr(`OFS_CRC_CONTROL, 32'h300);
        wr(`OFS_CRC_VALUE, 32'hFFFFFFFF);
        rdc(`OFS_CRC_VALUE, 32'hF);
        // random taps and seed, one data byte shifted through
        v = rnd();
        wr(`OFS_CRC_TAP_MASK, v);
        wr(`OFS_CRC_VALUE, ~v);
        crc_data_valid <= 1'b1;
        crc_data <= v[31:16];
        @(posedge pclk);
        crc_data_valid <= 1'b0;
        @(posedge pclk);
        rdc(`OFS_CRC_VALUE, lfsr(~v, v, v[23:16]));
        // two interrupt-started cells of four bytes make one eight-byte block
        v = rnd();
        s = v[7:0];
        a = ~s;
        beats <= 8'h04;
        slow <= 1'b1;
        wr(`OFS_SOURCE_SIZE, 32'h8);
        wr(`OFS_DEST_SIZE, 32'h8);
        wr(`OFS_CELL_SIZE, 32'h4);
        wr(`OFS_CHANNEL_CONTROL, 32'h1);
        wr(`OFS_INT_CONTROL, 32'h00FF0000);
        wr(`OFS_EVENT_CONTROL, {8'h0, a, s, 8'h10});
        fire(s ^ 8'h01);
        check(busy, 1'b0);
        fire(s);
        check(busy, 1'b1);
        wait_idle();
        rdc(`OFS_INT_CONTROL, 32'h00FF0054);
        check(irq, 1'b1);
        fire(s);
        wait_idle();
        rdc(`OFS_INT_CONTROL, 32'h00FF00FC);
        wr(`OFS_INT_CONTROL, 32'h00FE0000);
        check(irq, 1'b0);
        address_error <= 1'b1;
        @(posedge pclk);
        address_error <= 1'b0;
        @(posedge pclk);
        rdc(`OFS_INT_CONTROL, 32'h00FE0001);
        check(irq, 1'b0);
        wr(`OFS_INT_CONTROL, 32'h00FF0000);
        // same event with its enable on must raise the request
        address_error <= 1'b1;
        @(posedge pclk);
        address_error <= 1'b0;
        @(posedge pclk);
        check(irq, 1'b1);
        wr(`OFS_INT_CONTROL, 32'h00FF0000);
        // forced start with no data, then aborts of each kind
        beats <= 8'h00;
        wr(`OFS_CHANNEL_CONTROL, 32'h1);
        wr(`OFS_EVENT_CONTROL, {8'h0, a, s, 8'h90});
        check(busy, 1'b1);
        fire(a);
        check(busy, 1'b1);
        wr(`OFS_EVENT_CONTROL, {8'h0, a, s, 8'hC8});
        check(busy, 1'b0);
        rdc(`OFS_EVENT_CONTROL, {8'h0, a, s, 8'h08});
        rdc(`OFS_INT_CONTROL, 32'h00FF0000);
        wr(`OFS_EVENT_CONTROL, {8'h0, a, s, 8'h88});
        fire(a);
        check(busy, 1'b0);
        rdc(`OFS_INT_CONTROL, 32'h00FF0002);
        wr(`OFS_INT_CONTROL, 32'h00FF0000);
        wr(`OFS_EVENT_CONTROL, {8'h0, a, s, 8'hA0});
        pattern_match <= 1'b1;
        @(posedge pclk);
        pattern_match <= 1'b0;
        @(posedge pclk);
        check(busy, 1'b0);
        rdc(`OFS_INT_CONTROL, 32'h00FF0008);
        rdc(`OFS_CHANNEL_CONTROL, 32'h0);
        close_out();
    end
endmodule // dma_channel_event_and_crc_tb
